/* hw/pmrcc_pkg.sv */
// package: register map, field positions and reset values of the regulator and clock configuration bank
package pmrcc_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_REG_ENABLE_CTRL = 12'h000;
    localparam logic [11:0] ADDR_SLEW_THERMAL = 12'h004;
    localparam logic [11:0] ADDR_ANALOG_MUX = 12'h008;
    localparam logic [11:0] ADDR_OSC_CLOCK = 12'h00c;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int EN_REQ_LSB = 8;
    localparam int EN_REQ_W = 4;
    localparam int THERM_LSB = 16;
    localparam int THERM_W = 6;
    localparam int BOOST_SLEW_LSB = 22;
    localparam int PRE_LS_LSB = 11;
    localparam int PRE_HS_LSB = 8;
    localparam int RATIO_BIT = 13;
    localparam int MEAS_LSB = 8;
    localparam int MEAS_W = 5;
    localparam int SPREAD_PROF_BIT = 23;
    localparam int OUT_SRC_LSB = 19;
    localparam int OUT_PHASE_LSB = 16;
    localparam int OUT_RATE_BIT = 15;
    localparam int EXT_SEL_BIT = 14;
    localparam int EXT_DIV_BIT = 13;
    localparam int SPREAD_EN_BIT = 12;
    localparam int TUNE_LSB = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0] PRE_LS_RESET = 2'h3;
    localparam logic [1:0] SLEW_ZERO = 2'h0;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // decoded setting bundles
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] boost_low_side_slew;
        logic [1:0] pre_reg_low_side_drive;
        logic [1:0] pre_reg_high_side_drive;
        logic [5:0] thermal_action;
    } pmrcc_reg_cfg_type;

    typedef struct packed {
        logic spread_profile_select;
        logic spread_enable;
        logic [3:0] clock_out_source_select;
        logic [2:0] clock_out_phase;
        logic clock_out_rate_select;
        logic external_sync_divider;
        logic [3:0] clock_tune;
    } pmrcc_clk_cfg_type;

endpackage

/* hw/pmrcc_regs.sv */
// module: apb register bank for regulator, analog measurement and oscillator configuration
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// Operation
// RULE1 - a 1 written to enable-request bits 11:8 pulses a turn-on request for that regulator and a 0 does nothing.
// RULE2 - a thermal action bit at 0 makes a thermal shutdown only switch that regulator off.
// RULE3 - a thermal action bit at 1 switches the regulator off and also sends the device to deep fail-safe.
// RULE4 - bits 23:22 choose the boost low-side slew of 50, 100, 300 or 500 V/us.
// RULE5 - bits 12:11 choose the pre-regulator low-side drive of 130, 260, 520 or 900 mA.
// RULE6 - bits 9:8 choose the pre-regulator high-side drive with the same four codes.
// RULE7 - bit 13 of the measurement register chooses the low or high divider ratio.
// RULE8 - bit 23 of the clock register chooses the 23 kHz or 94 kHz spread profile.
// RULE9 - bit 12 of the clock register turns spread modulation off or on.
// RULE10 - bit 13 of the clock register divides the external sync input by 1 or 6.
// RULE11 - bits 18:16 delay the clock output by 0 to 7 cycles of the 20 MHz clock.
// RULE12 - a 1 written to bit 14 requests the external sync input, a 0 does nothing, and it reads as zero.
// RULE13 - reserved bits read zero and ignore writes, and request bits hold no readable state.
// RULE14 - at reset programmable fields load their one-time-programmed defaults and the rest their reset values; defaults load one clock after reset ends.
module pmrcc_regs
    import pmrcc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // one-time-programmed defaults
    input wire logic [1:0] i_otp_boost_slew,
    input wire logic [5:0] i_otp_thermal_action,
    input wire logic [1:0] i_otp_pre_hs_drive,
    // thermal shutdown events, one per regulator
    input wire logic [5:0] i_thermal_shutdown,
    // regulator control
    output logic [3:0] o_reg_on_req,
    output logic [5:0] o_reg_off,
    output logic o_deep_fail_safe_req,
    output logic [1:0] o_boost_low_side_slew,
    output logic [1:0] o_pre_reg_low_side_drive,
    output logic [1:0] o_pre_reg_high_side_drive,
    // analog measurement
    output logic o_divider_ratio_high,
    output logic [4:0] o_measure_channel_select,
    // clock control
    output logic o_external_sync_select_req,
    output pmrcc_clk_cfg_type o_clk_cfg
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    pmrcc_reg_cfg_type reg_cfg_r, reg_cfg_nxt;
    pmrcc_clk_cfg_type clk_cfg_r, clk_cfg_nxt;
    logic divider_ratio_high_r, divider_ratio_high_nxt;
    logic [4:0] measure_channel_select_r, measure_channel_select_nxt;
    logic [3:0] reg_on_req_r, reg_on_req_nxt;
    logic ext_sel_req_r, ext_sel_req_nxt;
    logic [5:0] reg_off_r, reg_off_nxt;
    logic deep_fail_safe_r, deep_fail_safe_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic otp_load_r;
    logic access;
    logic wr;
    logic hit;
    logic [31:0] rd_word;

    assign access = i_psel && i_penable && !pready_r;
    assign wr = access && i_pwrite && (i_pstrb[1] || i_pstrb[2]);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_word = DATA_ZERO;
        hit = 1'b1;
        unique case (i_paddr)
            ADDR_REG_ENABLE_CTRL: begin
                rd_word = DATA_ZERO; // RULE13
            end
            ADDR_SLEW_THERMAL: begin
                rd_word[BOOST_SLEW_LSB +: 2] = reg_cfg_r.boost_low_side_slew;
                rd_word[THERM_LSB +: THERM_W] = reg_cfg_r.thermal_action;
                rd_word[PRE_LS_LSB +: 2] = reg_cfg_r.pre_reg_low_side_drive;
                rd_word[PRE_HS_LSB +: 2] = reg_cfg_r.pre_reg_high_side_drive;
            end
            ADDR_ANALOG_MUX: begin
                rd_word[RATIO_BIT] = divider_ratio_high_r;
                rd_word[MEAS_LSB +: MEAS_W] = measure_channel_select_r;
            end
            ADDR_OSC_CLOCK: begin
                rd_word[SPREAD_PROF_BIT] = clk_cfg_r.spread_profile_select;
                rd_word[OUT_SRC_LSB +: 4] = clk_cfg_r.clock_out_source_select;
                rd_word[OUT_PHASE_LSB +: 3] = clk_cfg_r.clock_out_phase;
                rd_word[OUT_RATE_BIT] = clk_cfg_r.clock_out_rate_select;
                rd_word[EXT_DIV_BIT] = clk_cfg_r.external_sync_divider;
                rd_word[SPREAD_EN_BIT] = clk_cfg_r.spread_enable;
                rd_word[TUNE_LSB +: 4] = clk_cfg_r.clock_tune;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        reg_cfg_nxt = reg_cfg_r;
        clk_cfg_nxt = clk_cfg_r;
        divider_ratio_high_nxt = divider_ratio_high_r;
        measure_channel_select_nxt = measure_channel_select_r;
        reg_on_req_nxt = '0;
        ext_sel_req_nxt = 1'b0;
        pready_nxt = access;
        pslverr_nxt = access && !hit;
        prdata_nxt = (access && !i_pwrite && hit) ? rd_word : DATA_ZERO;
        if (otp_load_r) begin
            reg_cfg_nxt.boost_low_side_slew = i_otp_boost_slew; // RULE14
            reg_cfg_nxt.thermal_action = i_otp_thermal_action; // RULE14
            reg_cfg_nxt.pre_reg_high_side_drive = i_otp_pre_hs_drive; // RULE14
        end else if (wr) begin
            unique case (i_paddr)
                ADDR_REG_ENABLE_CTRL: begin
                    reg_on_req_nxt = i_pwdata[EN_REQ_LSB +: EN_REQ_W]; // RULE1
                end
                ADDR_SLEW_THERMAL: begin
                    reg_cfg_nxt.boost_low_side_slew = i_pwdata[BOOST_SLEW_LSB +: 2]; // RULE4
                    reg_cfg_nxt.thermal_action = i_pwdata[THERM_LSB +: THERM_W];
                    reg_cfg_nxt.pre_reg_low_side_drive = i_pwdata[PRE_LS_LSB +: 2]; // RULE5
                    reg_cfg_nxt.pre_reg_high_side_drive = i_pwdata[PRE_HS_LSB +: 2]; // RULE6
                end
                ADDR_ANALOG_MUX: begin
                    divider_ratio_high_nxt = i_pwdata[RATIO_BIT]; // RULE7
                    measure_channel_select_nxt = i_pwdata[MEAS_LSB +: MEAS_W];
                end
                ADDR_OSC_CLOCK: begin
                    clk_cfg_nxt.spread_profile_select = i_pwdata[SPREAD_PROF_BIT]; // RULE8
                    clk_cfg_nxt.clock_out_source_select = i_pwdata[OUT_SRC_LSB +: 4];
                    clk_cfg_nxt.clock_out_phase = i_pwdata[OUT_PHASE_LSB +: 3]; // RULE11
                    clk_cfg_nxt.clock_out_rate_select = i_pwdata[OUT_RATE_BIT];
                    ext_sel_req_nxt = i_pwdata[EXT_SEL_BIT]; // RULE12
                    clk_cfg_nxt.external_sync_divider = i_pwdata[EXT_DIV_BIT]; // RULE10
                    clk_cfg_nxt.spread_enable = i_pwdata[SPREAD_EN_BIT]; // RULE9
                    clk_cfg_nxt.clock_tune = i_pwdata[TUNE_LSB +: 4];
                end
                default: begin
                end
            endcase
        end
        // thermal events: switch off always, fail-safe only where the action bit is set
        reg_off_nxt = i_thermal_shutdown; // RULE2
        deep_fail_safe_nxt = |(i_thermal_shutdown & reg_cfg_r.thermal_action); // RULE3
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            reg_cfg_r.boost_low_side_slew <= SLEW_ZERO;
            reg_cfg_r.thermal_action <= '0;
            reg_cfg_r.pre_reg_low_side_drive <= PRE_LS_RESET; // RULE14
            reg_cfg_r.pre_reg_high_side_drive <= SLEW_ZERO;
            clk_cfg_r <= '0;
            divider_ratio_high_r <= 1'b0;
            measure_channel_select_r <= '0;
            reg_on_req_r <= '0;
            ext_sel_req_r <= 1'b0;
            reg_off_r <= '0;
            deep_fail_safe_r <= 1'b0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= DATA_ZERO;
            otp_load_r <= 1'b1;
        end else begin
            reg_cfg_r <= reg_cfg_nxt;
            clk_cfg_r <= clk_cfg_nxt;
            divider_ratio_high_r <= divider_ratio_high_nxt;
            measure_channel_select_r <= measure_channel_select_nxt;
            reg_on_req_r <= reg_on_req_nxt;
            ext_sel_req_r <= ext_sel_req_nxt;
            reg_off_r <= reg_off_nxt;
            deep_fail_safe_r <= deep_fail_safe_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
            otp_load_r <= 1'b0;
        end
    end

    assign o_pready = pready_r;
    assign o_prdata = prdata_r;
    assign o_pslverr = pslverr_r;
    assign o_reg_on_req = reg_on_req_r;
    assign o_reg_off = reg_off_r;
    assign o_deep_fail_safe_req = deep_fail_safe_r;
    assign o_boost_low_side_slew = reg_cfg_r.boost_low_side_slew;
    assign o_pre_reg_low_side_drive = reg_cfg_r.pre_reg_low_side_drive;
    assign o_pre_reg_high_side_drive = reg_cfg_r.pre_reg_high_side_drive;
    assign o_divider_ratio_high = divider_ratio_high_r;
    assign o_measure_channel_select = measure_channel_select_r;
    assign o_external_sync_select_req = ext_sel_req_r;
    assign o_clk_cfg = clk_cfg_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_on_req;
        @(posedge i_clk) disable iff (!i_rst_b)
        (wr && i_paddr == ADDR_REG_ENABLE_CTRL && !otp_load_r) |=> (o_reg_on_req == $past(i_pwdata[11:8]));
    endproperty
    a_on_req: assert property (p_on_req) else $error("on request does not follow write"); // RULE1

    property p_on_req_pulse;
        @(posedge i_clk) disable iff (!i_rst_b)
        (o_reg_on_req != 4'h0) |=> (o_reg_on_req == 4'h0);
    endproperty
    a_on_req_pulse: assert property (p_on_req_pulse) else $error("on request held"); // RULE13

    property p_off;
        @(posedge i_clk) disable iff (!i_rst_b)
        1'b1 |=> (o_reg_off == $past(i_thermal_shutdown));
    endproperty
    a_off: assert property (p_off) else $error("thermal off missing"); // RULE2

    property p_deep_fail_safe;
        @(posedge i_clk) disable iff (!i_rst_b)
        1'b1 |=> (o_deep_fail_safe_req == |($past(i_thermal_shutdown) & $past(reg_cfg_r.thermal_action)));
    endproperty
    a_deep_fail_safe: assert property (p_deep_fail_safe) else $error("fail-safe request wrong"); // RULE3

    property p_boost_slew;
        @(posedge i_clk) disable iff (!i_rst_b)
        (wr && i_paddr == ADDR_SLEW_THERMAL && !otp_load_r) |=> (o_boost_low_side_slew == $past(i_pwdata[23:22]));
    endproperty
    a_boost_slew: assert property (p_boost_slew) else $error("boost slew not stored"); // RULE4

    property p_pre_drive;
        @(posedge i_clk) disable iff (!i_rst_b)
        (wr && i_paddr == ADDR_SLEW_THERMAL && !otp_load_r) |=>
            (o_pre_reg_low_side_drive == $past(i_pwdata[12:11]) && o_pre_reg_high_side_drive == $past(i_pwdata[9:8]));
    endproperty
    a_pre_drive: assert property (p_pre_drive) else $error("pre-regulator drive not stored"); // RULE5

    property p_ratio;
        @(posedge i_clk) disable iff (!i_rst_b)
        (wr && i_paddr == ADDR_ANALOG_MUX && !otp_load_r) |=> (o_divider_ratio_high == $past(i_pwdata[13]));
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio not stored"); // RULE7

    property p_clock;
        @(posedge i_clk) disable iff (!i_rst_b)
        (wr && i_paddr == ADDR_OSC_CLOCK && !otp_load_r) |=>
            (o_clk_cfg.spread_profile_select == $past(i_pwdata[23]) && o_clk_cfg.spread_enable == $past(i_pwdata[12])
             && o_clk_cfg.external_sync_divider == $past(i_pwdata[13]) && o_clk_cfg.clock_out_phase == $past(i_pwdata[18:16])
             && o_external_sync_select_req == $past(i_pwdata[14]));
    endproperty
    a_clock: assert property (p_clock) else $error("clock fields not stored"); // RULE8

    property p_ext_rd;
        @(posedge i_clk) disable iff (!i_rst_b)
        (access && !i_pwrite && i_paddr == ADDR_OSC_CLOCK) |=> (o_prdata[14] == 1'b0 && o_prdata[31:24] == 8'h00);
    endproperty
    a_ext_rd: assert property (p_ext_rd) else $error("reserved bit reads nonzero"); // RULE12

    property p_ready;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_psel && i_penable && !o_pready) |=> o_pready ##1 !o_pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready timing wrong"); // RULE13

    property p_slverr;
        @(posedge i_clk) disable iff (!i_rst_b)
        (access && !hit) |=> (o_pready && o_pslverr && o_prdata == DATA_ZERO);
    endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped access not refused"); // RULE13

    property p_rdata_idle;
        @(posedge i_clk) disable iff (!i_rst_b)
        !o_pready |-> (o_prdata == DATA_ZERO && !o_pslverr);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data or error outside answer"); // RULE13

    property p_strobe_ignore;
        @(posedge i_clk) disable iff (!i_rst_b)
        (access && i_pwrite && !i_pstrb[1] && !i_pstrb[2] && i_paddr == ADDR_REG_ENABLE_CTRL) |=> (o_reg_on_req == 4'h0);
    endproperty
    a_strobe_ignore: assert property (p_strobe_ignore) else $error("request without field strobe"); // RULE1

    property p_otp_load;
        @(posedge i_clk) disable iff (!i_rst_b)
        (otp_load_r && i_rst_b) |=>
            (o_boost_low_side_slew == $past(i_otp_boost_slew) && o_pre_reg_high_side_drive == $past(i_otp_pre_hs_drive));
    endproperty
    a_otp_load: assert property (p_otp_load) else $error("programmed defaults not loaded"); // RULE14

endmodule
`default_nettype wire

/* testbench/pmrcc_regs_test.sv */
// testbench: self-checking apb scenarios for the regulator and clock configuration bank
`timescale 1ns/1ns
`default_nettype none

module pmrcc_regs_test;
    import pmrcc_pkg::*;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [1:0] otp_boost = 2'h2;
    logic [5:0] otp_therm = 6'h2a;
    logic [1:0] otp_hs = 2'h1;
    logic [5:0] thermal_shutdown = 6'h00;
    logic pready, pslverr, dfs, ratio, ext_req;
    logic [31:0] prdata, rd_data;
    logic [3:0] on_req, cap_on;
    logic [5:0] reg_off;
    logic [1:0] boost_slew, pre_ls, pre_hs;
    logic [4:0] meas;
    logic rd_err, cap_ext;
    pmrcc_clk_cfg_type clk_cfg;
    int failures = 0;
    int check_count = 0;

    always #2 clk = ~clk;

    pmrcc_regs dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(pslverr), .i_otp_boost_slew(otp_boost), .i_otp_thermal_action(otp_therm),
        .i_otp_pre_hs_drive(otp_hs), .i_thermal_shutdown(thermal_shutdown), .o_reg_on_req(on_req), .o_reg_off(reg_off),
        .o_deep_fail_safe_req(dfs), .o_boost_low_side_slew(boost_slew), .o_pre_reg_low_side_drive(pre_ls),
        .o_pre_reg_high_side_drive(pre_hs), .o_divider_ratio_high(ratio), .o_measure_channel_select(meas),
        .o_external_sync_select_req(ext_req), .o_clk_cfg(clk_cfg));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // setup, access until pready is seen high at a rising edge; answer taken at that edge, then release
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk("pready", 32'h1, 32'h0);
        rd_data = prdata;
        rd_err = pslverr;
        cap_on = on_req;
        cap_ext = ext_req;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("rst ls", 32'h3, 32'(pre_ls));
        chk("rst boost", 32'h0, 32'(boost_slew));
        @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, ADDR_SLEW_THERMAL, 32'h0, 4'h0);
        chk("otp slew", 32'h00aa1900, rd_data);
        chk("otp boost", 32'h2, 32'(boost_slew));
        chk("otp hs", 32'h1, 32'(pre_hs));
        apb(1'b0, ADDR_ANALOG_MUX, 32'h0, 4'h0);
        chk("amux rst", 32'h0, rd_data);
        apb(1'b0, ADDR_OSC_CLOCK, 32'h0, 4'h0);
        chk("clock rst", 32'h0, rd_data);
    endtask

    task automatic t_enable();
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, ADDR_REG_ENABLE_CTRL, 32'hffff_00ff | (32'(i) << 8) & 32'h0000_0f00, 4'hf);
            chk("on pulse", 32'(i), 32'(cap_on));
            @(negedge clk);
            chk("on pulse end", 32'h0, 32'(on_req));
        end
        apb(1'b1, ADDR_REG_ENABLE_CTRL, 32'h0000_0f00, 4'h1);
        chk("strobe off", 32'h0, 32'(cap_on));
        apb(1'b0, ADDR_REG_ENABLE_CTRL, 32'h0, 4'h0);
        chk("enable read", 32'h0, rd_data);
    endtask

    task automatic t_slew();
        logic [31:0] w;
        for (int i = 0; i < 4; i++) begin
            w = 32'hff00e4ff | (32'(i) << 22) | (32'(3 - i) << 11) | (32'(i ^ 1) << 8) | (32'(i * 9) << 16);
            apb(1'b1, ADDR_SLEW_THERMAL, w, 4'hf);
            chk("boost slew", 32'(i), 32'(boost_slew));
            chk("ls drive", 32'(3 - i), 32'(pre_ls));
            chk("hs drive", 32'(i ^ 1), 32'(pre_hs));
            apb(1'b0, ADDR_SLEW_THERMAL, 32'h0, 4'h0);
            chk("slew read", w & 32'h00ff1b00, rd_data);
        end
    endtask

    task automatic t_thermal();
        logic [5:0] act;
        for (int k = 0; k < 2; k++) begin
            act = (k == 0) ? 6'h00 : 6'h2a;
            apb(1'b1, ADDR_SLEW_THERMAL, 32'(act) << 16, 4'h4);
            for (int b = 0; b < 6; b++) begin
                @(posedge clk);
                thermal_shutdown <= 6'(1 << b);
                @(posedge clk);
                thermal_shutdown <= 6'h00;
                @(negedge clk);
                chk("reg off", 32'(1 << b), 32'(reg_off));
                chk("deep fail safe", 32'(act[b]), 32'(dfs));
            end
        end
    endtask

    task automatic t_amux();
        logic [31:0] w;
        for (int i = 0; i < 4; i++) begin
            w = 32'hff00c0ff | (32'(i & 1) << 13) | (32'((i * 11) & 31) << 8);
            apb(1'b1, ADDR_ANALOG_MUX, w, 4'hf);
            chk("ratio", 32'(i & 1), 32'(ratio));
            chk("channel", 32'((i * 11) & 31), 32'(meas));
            apb(1'b0, ADDR_ANALOG_MUX, 32'h0, 4'h0);
            chk("amux read", w & 32'h00003f00, rd_data);
        end
    endtask

    task automatic t_clock();
        logic [31:0] w;
        logic [14:0] e;
        for (int i = 0; i < 8; i++) begin
            w = {8'h5a, i[0], 4'(i + 3), i[2:0], i[1], i[0], ~i[0], i[2], 4'(i * 2 + 1), 8'hff};
            e = {w[23], w[12], w[22:19], w[18:16], w[15], w[13], w[11:8]};
            apb(1'b1, ADDR_OSC_CLOCK, w, 4'hf);
            chk("clk cfg", 32'(e), 32'(clk_cfg));
            chk("ext sel pulse", 32'(i[0]), 32'(cap_ext));
            apb(1'b0, ADDR_OSC_CLOCK, 32'h0, 4'h0);
            chk("clock read", w & 32'h00ffbf00, rd_data);
        end
    endtask

    task automatic t_unmapped();
        apb(1'b1, 12'h010, 32'hffff_ffff, 4'hf);
        chk("unmapped wr err", 32'h1, 32'(rd_err));
        apb(1'b0, 12'h010, 32'h0, 4'h0);
        chk("unmapped rd err", 32'h1, 32'(rd_err));
        chk("unmapped rd data", 32'h0, rd_data);
        apb(1'b0, ADDR_OSC_CLOCK, 32'h0, 4'h0);
        chk("mapped err", 32'h0, 32'(rd_err));
    endtask

    // ------------------------------------------------------------
    // verdict, main sequence and watchdog
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        t_reset();
        t_enable();
        t_slew();
        t_thermal();
        t_amux();
        t_clock();
        t_unmapped();
        conclude();
    end

    initial begin
        #80000;
        failures++;
        conclude();
    end
endmodule

`default_nettype wire
